// >>> ivm_vector_map.v
// Top of the interrupt vector map. Peripheral request pulses set pending
// flags; enables and priority words gate them; the winner is offered to
// the core as a vector number and a table entry address.
// Assumes one clock, synchronous active-low reset, AXI4-Lite master.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`include "ivm_map.vh"

module ivm_vector_map #(
    parameter HAS_CAN = 1
) (
    aclk,
    aresetn,
    src_req,
    core_ack,
    core_req,
    core_vector,
    core_irq_num,
    core_tbl_addr,
    core_level,
    irq,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready
);
    input wire aclk;
    input wire aresetn;
    input wire [47:0] src_req;
    input wire core_ack;
    output reg core_req;
    output reg [7:0] core_vector;
    output reg [5:0] core_irq_num;
    output reg [23:0] core_tbl_addr;
    output reg [2:0] core_level;
    output reg irq;
    input wire [11:0] s_axi_awaddr;
    input wire s_axi_awvalid;
    output reg s_axi_awready;
    input wire [31:0] s_axi_wdata;
    input wire [3:0] s_axi_wstrb;
    input wire s_axi_wvalid;
    output reg s_axi_wready;
    output reg [1:0] s_axi_bresp;
    output reg s_axi_bvalid;
    input wire s_axi_bready;
    input wire [11:0] s_axi_araddr;
    input wire s_axi_arvalid;
    output reg s_axi_arready;
    output reg [31:0] s_axi_rdata;
    output reg [1:0] s_axi_rresp;
    output reg s_axi_rvalid;
    input wire s_axi_rready;

    localparam NPRI = `IVM_PRI_WORDS;

    // Implemented request lines; CAN lines drop out on other variants
    wire [47:0] valid_req;
    assign valid_req = {`IVM_VALID_W2 & (HAS_CAN ? 16'hffff : ~`IVM_CAN_W2),
                        `IVM_VALID_W1, `IVM_VALID_W0};

    reg [47:0] flag_r;     // Pending flags, three 16-bit words
    reg [47:0] en_r;       // Enable bits, same layout
    reg [1:0] mask_r;      // Event interrupt mask
    reg [1:0] stat_r;      // Sticky event status
    reg [15:0] wr_mask;    // Byte-enable expansion, low half only

    // Write channel capture: address and data may come in either order
    reg aw_hold_r;
    reg w_hold_r;
    reg [11:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    wire wr_go;
    assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;

    // Priority words, one slot each, written through their own strobe
    wire [15:0] pri_word [0:NPRI-1];
    wire [NPRI*16-1:0] pri_bus;
    genvar g;
    generate
        for (g = 0; g < NPRI; g = g + 1) begin : g_pri
            ivm_pri_slot #(
                .RESET_VAL(`IVM_PRI_RESET)
            ) u_slot (
                .aclk(aclk),
                .aresetn(aresetn),
                .wr_en(wr_go && aw_addr_r == (`IVM_OFF_PRI_BASE + g * 4)),
                .wr_data(w_data_r[15:0]),
                .word(pri_word[g])
            );
            assign pri_bus[g*16 +: 16] = pri_word[g];
        end
    endgenerate

    // Field k of request n lives in word n/4, bits (n%4)*4+2 : (n%4)*4,
    // which puts request 1 at bits 6:4 of word 0 and 40 at 2:0 of word 10
    wire [47*3+2:0] pri_flat;
    generate
        for (g = 0; g < 48; g = g + 1) begin : g_field
            if (g / 4 < NPRI) begin : g_have
                assign pri_flat[g*3 +: 3] = pri_bus[(g/4)*16 + (g%4)*4 +: 3];
            end else begin : g_none
                assign pri_flat[g*3 +: 3] = 3'h0;
            end
        end
    endgenerate

    // A line competes only with flag and enable both set
    wire [47:0] active;
    assign active = flag_r & en_r & valid_req;

    wire found;
    wire [5:0] win_idx;
    wire [2:0] win_pri;
    ivm_arbiter #(
        .NREQ(`IVM_NREQ)
    ) u_arb (
        .active(active),
        .pri_flat(pri_flat),
        .found(found),
        .win_idx(win_idx),
        .win_pri(win_pri)
    );

    // Acknowledge clears the offered flag, but a fresh pulse wins
    wire ack_take;
    assign ack_take = core_ack && core_req;
    wire [47:0] ack_clr;
    assign ack_clr = ack_take ? (48'h1 << core_irq_num) : 48'h0;
    reg [47:0] sw_clr;     // Software clears, write one to clear

    always @* begin
        wr_mask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
        sw_clr = 48'h0;
        if (wr_go) begin
            if (aw_addr_r == `IVM_OFF_FLAG0) begin
                sw_clr[15:0] = w_data_r[15:0] & wr_mask;
            end else if (aw_addr_r == `IVM_OFF_FLAG1) begin
                sw_clr[31:16] = w_data_r[15:0] & wr_mask;
            end else if (aw_addr_r == `IVM_OFF_FLAG2) begin
                sw_clr[47:32] = w_data_r[15:0] & wr_mask;
            end
        end
    end

    // Pending flags: set by source pulse, set beats clear in one cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            flag_r <= {`IVM_FLAG_RESET, `IVM_FLAG_RESET, `IVM_FLAG_RESET};
        end else begin
            flag_r <= ((flag_r & ~(sw_clr | ack_clr)) | src_req) & valid_req;
        end
    end

    // Enables, mask and write response
    always @(posedge aclk) begin
        if (!aresetn) begin
            en_r <= {`IVM_EN_RESET, `IVM_EN_RESET, `IVM_EN_RESET};
            mask_r <= `IVM_MASK_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                if (aw_addr_r == `IVM_OFF_EN0) begin
                    en_r[15:0] <= ((en_r[15:0] & ~wr_mask) | (w_data_r[15:0] & wr_mask))
                                  & `IVM_VALID_W0;
                end else if (aw_addr_r == `IVM_OFF_EN1) begin
                    en_r[31:16] <= ((en_r[31:16] & ~wr_mask) | (w_data_r[15:0] & wr_mask))
                                   & `IVM_VALID_W1;
                end else if (aw_addr_r == `IVM_OFF_EN2) begin
                    en_r[47:32] <= ((en_r[47:32] & ~wr_mask) | (w_data_r[15:0] & wr_mask))
                                   & valid_req[47:32];
                end else if (aw_addr_r == `IVM_OFF_MASK) begin
                    mask_r <= w_data_r[1:0];
                end else if (aw_addr_r == `IVM_OFF_FLAG0 || aw_addr_r == `IVM_OFF_FLAG1 ||
                             aw_addr_r == `IVM_OFF_FLAG2 || aw_addr_r == `IVM_OFF_STAT ||
                             aw_addr_r == `IVM_OFF_ACK ||
                             (aw_addr_r >= `IVM_OFF_PRI_BASE &&
                              aw_addr_r < `IVM_OFF_PRI_BASE + NPRI * 4)) begin
                    s_axi_bresp <= 2'h0;
                end else begin
                    s_axi_bresp <= 2'h2; // Unmapped: slave error
                end
            end
        end
    end

    // Write address and data hold until both are present
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
            end
        end
    end

    // Sticky events: new request offered, acknowledge taken; write one clears
    wire [1:0] ev_set;
    assign ev_set = {ack_take, found && !core_req};
    wire [1:0] ev_clr;
    assign ev_clr = (wr_go && aw_addr_r == `IVM_OFF_STAT) ? w_data_r[1:0] : 2'h0;

    always @(posedge aclk) begin
        if (!aresetn) begin
            stat_r <= 2'h0;
            irq <= 1'b0;
        end else begin
            stat_r <= (stat_r & ~ev_clr) | ev_set;
            irq <= |(((stat_r & ~ev_clr) | ev_set) & mask_r);
        end
    end

    // Core-facing vector: vector = request + 8, entry = 0x14 + 2*request
    always @(posedge aclk) begin
        if (!aresetn) begin
            core_req <= 1'b0;
            core_vector <= 8'h00;
            core_irq_num <= 6'h00;
            core_tbl_addr <= 24'h000000;
            core_level <= 3'h0;
        end else if (ack_take) begin
            core_req <= 1'b0; // One idle cycle so the cleared flag settles
        end else begin
            core_req <= found;
            core_irq_num <= win_idx;
            core_level <= win_pri;
            core_vector <= `IVM_VEC_BASE + {2'b00, win_idx};
            core_tbl_addr <= `IVM_TBL_BASE + {17'h00000, win_idx, 1'b0};
        end
    end

    // Read channel: one read at a time, decode by address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                s_axi_rdata <= 32'h00000000;
                if (s_axi_araddr[11:2] == `IVM_OFF_FLAG0 >> 2) begin
                    s_axi_rdata[15:0] <= flag_r[15:0];
                end else if (s_axi_araddr[11:2] == `IVM_OFF_FLAG1 >> 2) begin
                    s_axi_rdata[15:0] <= flag_r[31:16];
                end else if (s_axi_araddr[11:2] == `IVM_OFF_FLAG2 >> 2) begin
                    s_axi_rdata[15:0] <= flag_r[47:32];
                end else if (s_axi_araddr[11:2] == `IVM_OFF_EN0 >> 2) begin
                    s_axi_rdata[15:0] <= en_r[15:0];
                end else if (s_axi_araddr[11:2] == `IVM_OFF_EN1 >> 2) begin
                    s_axi_rdata[15:0] <= en_r[31:16];
                end else if (s_axi_araddr[11:2] == `IVM_OFF_EN2 >> 2) begin
                    s_axi_rdata[15:0] <= en_r[47:32];
                end else if (s_axi_araddr >= `IVM_OFF_PRI_BASE &&
                             s_axi_araddr < `IVM_OFF_PRI_BASE + NPRI * 4) begin
                    s_axi_rdata[15:0] <= pri_bus[(s_axi_araddr[5:2]) * 16 +: 16];
                end else if (s_axi_araddr[11:2] == `IVM_OFF_VEC >> 2) begin
                    // Live view of the offered vector and its table entry
                    s_axi_rdata <= {core_req, core_tbl_addr[22:0], core_vector};
                end else if (s_axi_araddr[11:2] == `IVM_OFF_MASK >> 2) begin
                    s_axi_rdata[1:0] <= mask_r;
                end else if (s_axi_araddr[11:2] == `IVM_OFF_STAT >> 2) begin
                    s_axi_rdata[1:0] <= stat_r;
                end else if (s_axi_araddr[11:2] == `IVM_OFF_ACK >> 2) begin
                    s_axi_rdata[2:0] <= core_level;
                end else begin
                    s_axi_rresp <= 2'h2; // Unmapped read: slave error, zero data
                end
            end
        end
    end
endmodule // ivm_vector_map

// >>> ivm_map.vh
// Constants for the interrupt vector map: register offsets, field layout,
// reset values and the vector/request/table figures of each mapped source.
// Assumes inclusion by bare name from the design files.
`ifndef IVM_MAP_VH
`define IVM_MAP_VH

// Register byte offsets on the AXI4-Lite bus
`define IVM_OFF_FLAG0    12'h000
`define IVM_OFF_FLAG1    12'h004
`define IVM_OFF_FLAG2    12'h008
`define IVM_OFF_EN0      12'h010
`define IVM_OFF_EN1      12'h014
`define IVM_OFF_EN2      12'h018
`define IVM_OFF_PRI_BASE 12'h040
`define IVM_OFF_VEC      12'h080
`define IVM_OFF_ACK      12'h084
`define IVM_OFF_MASK     12'h088
`define IVM_OFF_STAT     12'h08c

// Priority words: eleven of them, indices 0..10
`define IVM_PRI_WORDS    11
`define IVM_FLAG_RESET   16'h0000
`define IVM_EN_RESET     16'h0000
`define IVM_PRI_RESET    16'h4444
`define IVM_MASK_RESET   2'h0

// Event status bits
`define IVM_EV_REQ       0
`define IVM_EV_ACK       1

// Linear request line index = word*16 + bit (request numbers 0..47)
`define IVM_NREQ         48

// Vector number is request number plus this offset
`define IVM_VEC_BASE     8'h08
// Table entry is base plus twice the request number
`define IVM_TBL_BASE     24'h000014

// Valid (implemented) request mask: reserved 15, gaps of the variant
`define IVM_VALID_W0     16'h7fff
`define IVM_VALID_W1     16'hffff
`define IVM_VALID_W2     16'h01ff
// Request numbers that exist only on variants having the CAN port
`define IVM_CAN_W2       16'h000c

`endif

// >>> ivm_pri_slot.v
// One priority word slot: four 3-bit priority fields held in a 16-bit word.
// Assumes a synchronous active-low reset and a one-cycle write strobe.
module ivm_pri_slot #(
    parameter [15:0] RESET_VAL = 16'h4444
) (
    aclk,
    aresetn,
    wr_en,
    wr_data,
    word
);
    input wire aclk;
    input wire aresetn;
    input wire wr_en;
    input wire [15:0] wr_data;
    output reg [15:0] word;

    // Only bits 14:12, 10:8, 6:4, 2:0 hold fields; the gaps stay zero
    localparam [15:0] FIELD_MASK = 16'h7777;

    // Word register, reserved gaps forced low on write
    always @(posedge aclk) begin
        if (!aresetn) begin
            word <= RESET_VAL & FIELD_MASK;
        end else if (wr_en) begin
            word <= wr_data & FIELD_MASK;
        end
    end
endmodule // ivm_pri_slot

// >>> ivm_arbiter.v
// Picks the winning request: highest programmed priority, ties going to
// the lowest request number (natural order). Purely combinational.
// Assumes pending and priority vectors are already gated by the caller.
module ivm_arbiter #(
    parameter NREQ = 48
) (
    active,
    pri_flat,
    found,
    win_idx,
    win_pri
);
    input wire [NREQ-1:0] active;
    input wire [NREQ*3-1:0] pri_flat;
    output reg found;
    output reg [5:0] win_idx;
    output reg [2:0] win_pri;

    integer i;
    reg [2:0] p;

    // Scan from high to low index; non-strict greater-or-equal lets the lower
    // index replace an equal one, so the lowest number wins a tie
    always @* begin
        found = 1'b0;
        win_idx = 6'h00;
        win_pri = 3'h0;
        p = 3'h0;
        for (i = NREQ - 1; i >= 0; i = i - 1) begin
            p = pri_flat[i*3 +: 3];
            // Priority zero means the source is disabled in the core
            if (active[i] && (p != 3'h0) && (!found || p >= win_pri)) begin
                found = 1'b1;
                win_idx = i[5:0];
                win_pri = p;
            end
        end
    end
endmodule // ivm_arbiter

// >>> ivm_vector_map_chk.sv
// Checker for the vector map top: offer fields, ack handshake, bus answers.
// Assumes it is bound into ivm_vector_map and sees only its ports.
module ivm_vector_map_chk (
    input wire aclk,
    input wire aresetn,
    input wire core_ack,
    input wire core_req,
    input wire [7:0] core_vector,
    input wire [5:0] core_irq_num,
    input wire [23:0] core_tbl_addr,
    input wire [2:0] core_level,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Core takes the offer at this edge
    sequence s_take;
        core_req && core_ack;
    endsequence
    // Both write halves offered, address half not taken yet
    sequence s_wr_wait;
        s_axi_awvalid && s_axi_wvalid && !s_axi_awready;
    endsequence
    a_vec_offset: assert property (
        core_req |-> core_vector == {2'h0, core_irq_num} + 8'h08)
        else $error("vector is not request plus eight");
    a_tbl_entry: assert property (
        core_req |-> core_tbl_addr == 24'h000014 + {17'h0, core_irq_num, 1'b0})
        else $error("table entry does not follow request");
    a_ack_drop: assert property (s_take |=> !core_req)
        else $error("offer stayed up after the core took it");
    a_level_live: assert property (core_req |-> core_level != 3'h0)
        else $error("offer made at priority zero");
    a_no_reserved: assert property (
        core_req |-> core_irq_num != 6'h0f && core_irq_num <= 6'h28)
        else $error("offer made for a reserved request");
    a_wr_answer: assert property (s_wr_wait |-> ##[1:4] s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (s_axi_arvalid && !s_axi_arready |-> ##[1:3] s_axi_rvalid)
        else $error("read data late");
    a_rd_refused: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 0)
        else $error("refused read returned data");
    a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    a_ar_once: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("read address ready longer than one cycle");
endmodule // ivm_vector_map_chk

bind ivm_vector_map ivm_vector_map_chk ivm_vector_map_chk_i (.aclk, .aresetn, .core_ack,
    .core_req, .core_vector, .core_irq_num, .core_tbl_addr, .core_level, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);

// >>> ivm_core_model.sv
// Behavioural core that fetches offered vectors and logs what it took.
// Assumes the vector map's registered offer lines, one clock.
module ivm_core_model (
    input wire aclk,
    input wire aresetn,
    input wire take,
    input wire [7:0] delay,
    input wire core_req,
    input wire [7:0] core_vector,
    input wire [5:0] core_irq_num,
    input wire [23:0] core_tbl_addr,
    input wire [2:0] core_level,
    output logic core_ack,
    output logic [7:0] got_vec,
    output logic [5:0] got_num,
    output logic [23:0] got_tbl,
    output logic [2:0] got_lvl,
    output logic [7:0] got_n
);
    logic [7:0] wait_r; // Cycles the current offer has waited
    // Ack after delay cycles; the log holds the offer as seen at the ack edge,
    // since the winner may change while the core stalls
    always @(posedge aclk) begin
        if (!aresetn) begin
            core_ack <= 1'b0;
            wait_r <= 8'h00;
            got_n <= 8'h00;
        end else if (core_req && core_ack) begin
            core_ack <= 1'b0;
            wait_r <= 8'h00;
            got_vec <= core_vector;
            got_num <= core_irq_num;
            got_tbl <= core_tbl_addr;
            got_lvl <= core_level;
            got_n <= got_n + 8'h01;
        end else if (core_req && take) begin
            if (wait_r >= delay) core_ack <= 1'b1;
            else wait_r <= wait_r + 8'h01;
        end else begin
            // Stalled or nothing offered
            core_ack <= 1'b0;
            wait_r <= 8'h00;
        end
    end
endmodule // ivm_core_model

// >>> ivm_vector_map_tb_top.sv
// Self-checking bench for the vector map: table of sources, then interrupt,
// ties, gating, refused bus access and a second reset.
// Assumes the map header and the core model sit in the same folder.
`include "ivm_map.vh"
module ivm_vector_map_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int n, v, t, w, b, p, l;} ivm_row_t;
    logic aclk, aresetn, core_ack, core_req, irq, take, ia;
    logic [47:0] src_req;
    logic [7:0] core_vector, got_vec, got_n, delay;
    logic [5:0] core_irq_num, got_num;
    logic [23:0] core_tbl_addr, got_tbl;
    logic [2:0] core_level, got_lvl;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int bad_count, n_compared, c;
    ivm_row_t r;
    // Request, vector, table entry, word, bit, priority word, field low bit
    ivm_row_t rows [13] = '{'{0, 8, 'h14, 0, 0, 0, 0}, '{1, 9, 'h16, 0, 1, 0, 4},
        '{2, 10, 'h18, 0, 2, 0, 8}, '{4, 12, 'h1c, 0, 4, 1, 0},
        '{10, 18, 'h28, 0, 10, 2, 8}, '{11, 19, 'h2a, 0, 11, 2, 12},
        '{13, 21, 'h2e, 0, 13, 3, 4}, '{16, 24, 'h34, 1, 0, 4, 0},
        '{18, 26, 'h38, 1, 2, 4, 8}, '{19, 27, 'h3a, 1, 3, 4, 12},
        '{31, 39, 'h52, 1, 15, 7, 12}, '{34, 42, 'h58, 2, 2, 8, 8},
        '{40, 48, 'h64, 2, 8, 10, 0}};

    ivm_vector_map #(.HAS_CAN(1)) ivm_vector_map_i (.aclk, .aresetn, .src_req, .core_ack,
        .core_req, .core_vector, .core_irq_num, .core_tbl_addr, .core_level, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    ivm_core_model ivm_core_model_i (.aclk, .aresetn, .take, .delay, .core_req,
        .core_vector, .core_irq_num, .core_tbl_addr, .core_level, .core_ack, .got_vec,
        .got_num, .got_tbl, .got_lvl, .got_n);

    // Compare and count; unknowns never match
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Bus write; each half is dropped at the edge where it is taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && k < 60);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        chk("write answer", 32'(s_axi_bvalid), 1);
    endtask
    // Bus read; the address stays up until arready is sampled
    task automatic rd(input logic [11:0] a);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && k < 60);
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk("read answer", 32'(s_axi_rvalid), 1);
    endtask
    // One-cycle request pulse on the chosen lines
    task automatic pulse(input logic [47:0] m);
        @(posedge aclk);
        src_req <= m;
        @(posedge aclk);
        src_req <= 48'h0;
    endtask
    // Bounded wait until the core has taken cnt vectors in all
    task automatic wait_take(input int cnt);
        int k;
        k = 0;
        while (got_n != cnt && k < 200) begin
            @(posedge aclk);
            k++;
        end
        chk("take count", 32'(got_n), cnt);
    endtask
    task automatic test_done();
        if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Watchdog: the whole run needs well under this span
    initial begin
        #500000;
        bad_count++;
        test_done();
    end

    initial begin
        {aresetn, src_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf; // Full words only
        take = 1'b1;
        delay = 8'h00;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        // Each source alone: flag place, priority field place, offer fields
        foreach (rows[i]) begin
            r = rows[i];
            delay <= (i % 2 == 1) ? 8'h03 : 8'h00; // Odd rows meet a slow core
            take <= 1'b0;
            wr(12'(`IVM_OFF_EN0 + 4 * r.w), 32'h1 << r.b);
            wr(12'(`IVM_OFF_PRI_BASE + 4 * r.p), 32'h5 << r.l);
            pulse(48'h1 << r.n);
            rd(12'(`IVM_OFF_FLAG0 + 4 * r.w));
            chk("flag set", rdv, 32'h1 << r.b);
            // Register view of the pending offer: request bit, entry, vector
            rd(`IVM_OFF_VEC);
            chk("vector view", rdv, {1'b1, 23'(r.t), 8'(r.v)});
            rd(`IVM_OFF_ACK);
            chk("level view", rdv, 5);
            take <= 1'b1;
            wait_take(i + 1);
            chk("vector", 32'(got_vec), r.v);
            chk("table", 32'(got_tbl), r.t);
            chk("request", 32'(got_num), r.n);
            chk("level", 32'(got_lvl), 5);
            rd(12'(`IVM_OFF_FLAG0 + 4 * r.w));
            chk("flag clear", rdv, 0);
        end
        // Interrupt: sticky status, mask changes irq, write one clears
        rd(`IVM_OFF_STAT);
        chk("status", rdv, 32'h3);
        wr(`IVM_OFF_MASK, 32'h3);
        repeat (2) @(posedge aclk);
        ia = irq;
        wr(`IVM_OFF_MASK, 32'h0);
        repeat (2) @(posedge aclk);
        chk("irq on", 32'(ia), 1);
        chk("irq mask", 32'(irq), 0);
        wr(`IVM_OFF_STAT, 32'h3);
        repeat (2) @(posedge aclk);
        chk("irq clear", 32'(irq), 0);
        // Two pending at once: equal priority, then a raised higher number
        for (int j = 0; j < 2; j++) begin
            take <= 1'b0;
            wr(`IVM_OFF_PRI_BASE, j ? 32'h0640 : 32'h4444);
            wr(`IVM_OFF_EN0, 32'h6);
            pulse(48'h6);
            take <= 1'b1;
            c = got_n;
            wait_take(c + 1);
            chk("first", 32'(got_vec), j ? 10 : 9);
            wait_take(c + 2);
            chk("second", 32'(got_vec), j ? 9 : 10);
        end
        // Flag without enable, and a reserved line that must never latch
        wr(`IVM_OFF_EN0, 32'h8000);
        pulse(48'h8002);
        repeat (6) @(posedge aclk);
        chk("no offer", 32'(core_req), 0);
        rd(`IVM_OFF_FLAG0);
        chk("flags", rdv, 32'h2);
        wr(`IVM_OFF_FLAG0, 32'h2);
        rd(`IVM_OFF_FLAG0);
        chk("flag w1c", rdv, 0);
        // Only the upper byte lane is enabled; the reserved bit stays low
        s_axi_wstrb <= 4'h2;
        wr(`IVM_OFF_EN0, 32'hffff);
        rd(`IVM_OFF_EN0);
        chk("en strobe", rdv, 32'h7f00);
        s_axi_wstrb <= 4'hf;
        // Priority zero keeps an enabled source off the core
        wr(`IVM_OFF_PRI_BASE, 32'h0);
        wr(`IVM_OFF_EN0, 32'h2);
        pulse(48'h2);
        repeat (6) @(posedge aclk);
        chk("pri zero", 32'(core_req), 0);
        // Unmapped address is refused both ways
        wr(12'h0fc, 32'h1);
        chk("bresp", 32'(rsp), 2);
        rd(12'h0fc);
        chk("rresp", 32'(rsp), 2);
        chk("rdata", rdv, 0);
        // Second reset in mid-run, then reset values
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < `IVM_PRI_WORDS; k++) begin
            rd(12'(`IVM_OFF_PRI_BASE + 4 * k));
            chk("pri reset", rdv, 32'h4444);
        end
        rd(`IVM_OFF_FLAG0);
        chk("flag reset", rdv, 0);
        rd(`IVM_OFF_EN0);
        chk("en reset", rdv, 0);
        rd(`IVM_OFF_MASK);
        chk("mask reset", rdv, 0);
        chk("req reset", 32'(core_req), 0);
        chk("irq reset", 32'(irq), 0);
        rd(`IVM_OFF_STAT);
        chk("stat reset", rdv, 0);
        test_done();
    end
endmodule // ivm_vector_map_tb_top
